// File: ipdc_top.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ipdc_regs.svh"

// Function
// - primary ide irq uses upper nibble, reset 14
// - secondary ide irq uses lower nibble, reset 15
// - four 4-bit pci interrupt channel selectors
// - selectors 0,1,2,8,13 leave line unrouted
// - pci selectors reset to zero
// - timer base bits 15:2, reset 78h
// - timer claims io only while enabled
// - top of memory is field plus one megabytes
// - forward 1M to top, and above 16M
// - low bios block forwarded only when bit set, chip select overrides
// - video block forwarded only when bit set
// - 0-512K and 512-640K blocks individually enabled
// - eight 16K rom blocks individually forwarded
// - hole start holds address bits 23:16
// - enabled hole blocks forwarding, enable resets zero
// - hole size is a thermometer mask
module ipdc_top
	import ipdc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	// avalon-mm slave, word addressed
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// interrupt sources
	input  wire logic        ide_primary_irq,
	input  wire logic        ide_secondary_irq,
	input  wire logic [3:0]  pci_int_n,
	output logic [15:0]      irq_req,
	// pci io decode for the bios timer
	input  wire logic        io_valid,
	input  wire logic [15:0] io_addr,
	output logic             timer_hit,
	// isa master / dma memory decode
	input  wire logic        mem_valid,
	input  wire logic [31:0] mem_addr,
	output logic             mem_forward,
	output logic             mem_in_hole
);

	ipdc_state_s  s_q;
	ipdc_state_s  s_d;
	logic         dec_forward;
	logic         dec_in_hole;
	ipdc_region_e dec_region;

	// reserved channel codes leave the line unrouted
	function automatic logic channel_ok(input logic [3:0] ch);
		return !(ch == 4'h0 || ch == 4'h1 || ch == 4'h2
			|| ch == 4'h8 || ch == 4'hD);
	endfunction

	// one-hot of a routing channel
	function automatic logic [15:0] channel_bit(input logic [3:0] ch);
		return 16'h0001 << ch;
	endfunction

	// byte-lane merge for an 8-bit register
	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		return be[0] ? wd[7:0] : old;
	endfunction

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	ipdc_mem_decode u_mem_decode (
		.addr       (mem_addr),
		.decode     (s_q.decode),
		.rom_fwd    (s_q.rom_fwd),
		.hole_start (s_q.hole_start),
		.hole_size  (s_q.hole_size),
		.lbios_cs   (s_q.lbios_cs),
		.forward    (dec_forward),
		.in_hole    (dec_in_hole),
		.region     (dec_region)
	);

	logic        take;
	logic [31:0] rd;
	logic [15:0] route;
	logic [3:0]  line_ch;

	// next state: bus access, routing and decode results
	always_comb begin
		s_d  = s_q;
		take = (read || write) && !s_q.ack;
		rd   = 32'h0000_0000;
		line_ch = 4'h0;
		// one wait state: ack rises the cycle after the request appears
		s_d.ack = take;

		// read mux, sampled on the first cycle and held in a flop
		unique case (address)
			`IPDC_IDX_LINE_BUF:   rd[7:0]  = s_q.line_buf;
			`IPDC_IDX_IDE_ROUTE:  rd[7:0]  = s_q.ide_route;
			`IPDC_IDX_PCI_ROUTE:  rd[15:0] = s_q.pci_route;
			`IPDC_IDX_TIMER_BASE: rd[15:0] = s_q.timer_base;
			`IPDC_IDX_DECODE:     rd[7:0]  = s_q.decode;
			`IPDC_IDX_ROM_FWD:    rd[7:0]  = s_q.rom_fwd;
			`IPDC_IDX_HOLE_START: rd[7:0]  = s_q.hole_start;
			`IPDC_IDX_HOLE_SIZE:  rd[7:0]  = s_q.hole_size;
			`IPDC_IDX_CS_CTRL:    rd[`IPDC_LBIOS_CS_BIT] = s_q.lbios_cs;
			`IPDC_IDX_STATUS:     rd[7:0]  = {2'b00, s_q.mem_region,
				s_q.mem_in_hole, s_q.mem_forward, s_q.timer_hit};
			default:              rd = 32'h0000_0000;        // unmapped reads zero
		endcase
		if (read && take) begin
			s_d.readdata = rd;
		end

		// writes land on the edge where waitrequest is low
		if (write && s_q.ack) begin
			unique case (address)
				`IPDC_IDX_LINE_BUF: begin
					// only single transaction exists; other codes behave alike
					s_d.line_buf = merge8(s_q.line_buf, writedata, byteenable)
						& `IPDC_LINE_BUF_MASK;
				end
				`IPDC_IDX_IDE_ROUTE: begin
					s_d.ide_route = merge8(s_q.ide_route, writedata, byteenable);
				end
				`IPDC_IDX_PCI_ROUTE: begin
					s_d.pci_route = merge16(s_q.pci_route, writedata, byteenable);
				end
				`IPDC_IDX_TIMER_BASE: begin
					// bit 1 is reserved and reads zero
					s_d.timer_base = merge16(s_q.timer_base, writedata, byteenable)
						& `IPDC_TIMER_BASE_MASK;
				end
				`IPDC_IDX_DECODE: begin
					s_d.decode = merge8(s_q.decode, writedata, byteenable);
				end
				`IPDC_IDX_ROM_FWD: begin
					s_d.rom_fwd = merge8(s_q.rom_fwd, writedata, byteenable);
				end
				`IPDC_IDX_HOLE_START: begin
					s_d.hole_start = merge8(s_q.hole_start, writedata, byteenable);
				end
				`IPDC_IDX_HOLE_SIZE: begin
					s_d.hole_size = merge8(s_q.hole_size, writedata, byteenable);
				end
				`IPDC_IDX_CS_CTRL: begin
					if (byteenable[0]) begin
						s_d.lbios_cs = writedata[`IPDC_LBIOS_CS_BIT];
					end
				end
				default: begin
					// unmapped and read-only words ignore writes
				end
			endcase
		end

		// interrupt routing onto controller channels
		route = 16'h0000;
		if (ide_primary_irq) begin
			route = route | channel_bit(s_q.ide_route[7:4]);
		end
		if (ide_secondary_irq) begin
			route = route | channel_bit(s_q.ide_route[3:0]);
		end
		for (int i = 0; i < 4; i++) begin
			// line a sits in the top nibble, line d in the bottom
			line_ch = s_q.pci_route[(15 - 4 * i) -: 4];
			if (!pci_int_n[i] && channel_ok(line_ch)) begin
				route = route | channel_bit(line_ch);
			end
		end
		s_d.irq_req = route;

		// bios timer is the only io resource claimed on pci
		s_d.timer_hit = io_valid && s_q.timer_base[`IPDC_TIMER_EN_BIT]
			&& (io_addr[15:2] == s_q.timer_base[15:2]);

		// memory decode result; forward and hole flags cleared between accesses, region held
		if (mem_valid) begin
			s_d.mem_forward = dec_forward;
			s_d.mem_in_hole = dec_in_hole;
			s_d.mem_region  = dec_region;
		end else begin
			s_d.mem_forward = 1'b0;
			s_d.mem_in_hole = 1'b0;
		end
	end

	// single register stage for all state
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q.line_buf    <= `IPDC_RST_LINE_BUF;
			s_q.ide_route   <= `IPDC_RST_IDE_ROUTE;
			s_q.pci_route   <= `IPDC_RST_PCI_ROUTE;
			s_q.timer_base  <= `IPDC_RST_TIMER_BASE;
			s_q.decode      <= `IPDC_RST_DECODE;
			s_q.rom_fwd     <= `IPDC_RST_ROM_FWD;
			s_q.hole_start  <= `IPDC_RST_HOLE_START;
			s_q.hole_size   <= `IPDC_RST_HOLE_SIZE;
			s_q.lbios_cs    <= `IPDC_RST_CS_CTRL;
			s_q.ack         <= 1'b0;
			s_q.readdata    <= 32'h0000_0000;
			s_q.irq_req     <= 16'h0000;
			s_q.timer_hit   <= 1'b0;
			s_q.mem_forward <= 1'b0;
			s_q.mem_in_hole <= 1'b0;
			s_q.mem_region  <= IPDC_RGN_LOW;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs; waitrequest is combinational so a request stalls at once
	assign waitrequest = (read || write) && !s_q.ack;
	assign readdata    = s_q.readdata;
	assign irq_req     = s_q.irq_req;
	assign timer_hit   = s_q.timer_hit;
	assign mem_forward = s_q.mem_forward;
	assign mem_in_hole = s_q.mem_in_hole;

endmodule

`default_nettype wire

// File: ipdc_regs.svh
`ifndef IPDC_REGS_SVH
`define IPDC_REGS_SVH

// register indices; the bus word address equals the index
`define IPDC_IDX_LINE_BUF     8'h42
`define IPDC_IDX_IDE_ROUTE    8'h43
`define IPDC_IDX_PCI_ROUTE    8'h44
`define IPDC_IDX_TIMER_BASE   8'h46
`define IPDC_IDX_DECODE       8'h48
`define IPDC_IDX_ROM_FWD      8'h49
`define IPDC_IDX_HOLE_START   8'h4A
`define IPDC_IDX_HOLE_SIZE    8'h4B
`define IPDC_IDX_CS_CTRL      8'h4D
`define IPDC_IDX_STATUS       8'h50

// reset values
`define IPDC_RST_LINE_BUF     8'h00
`define IPDC_RST_IDE_ROUTE    8'hEF
`define IPDC_RST_PCI_ROUTE    16'h0000
`define IPDC_RST_TIMER_BASE   16'h0078
`define IPDC_RST_DECODE       8'h01
`define IPDC_RST_ROM_FWD      8'h00
`define IPDC_RST_HOLE_START   8'h00
`define IPDC_RST_HOLE_SIZE    8'h00
`define IPDC_RST_CS_CTRL      1'b0

// field positions
`define IPDC_TIMER_EN_BIT     0
`define IPDC_HOLE_EN_BIT      7
`define IPDC_LBIOS_CS_BIT     6
`define IPDC_DEC_LOWBIOS_BIT  3
`define IPDC_DEC_VIDEO_BIT    2
`define IPDC_DEC_640K_BIT     1
`define IPDC_DEC_512K_BIT     0
`define IPDC_LINE_BUF_MASK    8'h0F
`define IPDC_TIMER_BASE_MASK  16'hFFFD

`endif

// File: ipdc_pkg.sv
package ipdc_pkg;

	// which part of the ISA memory map an access fell into
	typedef enum logic [2:0] {
		IPDC_RGN_LOW    = 3'b000,
		IPDC_RGN_VIDEO  = 3'b001,
		IPDC_RGN_ROM    = 3'b010,
		IPDC_RGN_BIOS   = 3'b011,
		IPDC_RGN_EXT    = 3'b100,
		IPDC_RGN_HIGH   = 3'b101
	} ipdc_region_e;

	// whole register and output state of the block
	typedef struct packed {
		logic [7:0]   line_buf;
		logic [7:0]   ide_route;
		logic [15:0]  pci_route;
		logic [15:0]  timer_base;
		logic [7:0]   decode;
		logic [7:0]   rom_fwd;
		logic [7:0]   hole_start;
		logic [7:0]   hole_size;
		logic         lbios_cs;
		logic         ack;
		logic [31:0]  readdata;
		logic [15:0]  irq_req;
		logic         timer_hit;
		logic         mem_forward;
		logic         mem_in_hole;
		ipdc_region_e mem_region;
	} ipdc_state_s;

endpackage

// File: ipdc_mem_decode.sv
`timescale 1ns/10ps
`default_nettype none

module ipdc_mem_decode
	import ipdc_pkg::*;
(
	input  wire logic [31:0] addr,
	input  wire logic [7:0]  decode,
	input  wire logic [7:0]  rom_fwd,
	input  wire logic [7:0]  hole_start,
	input  wire logic [7:0]  hole_size,
	input  wire logic        lbios_cs,
	output logic             forward,
	output logic             in_hole,
	output ipdc_region_e     region
);

	// hole compare ignores address bits covered by the thermometer size mask
	function automatic logic hole_match(input logic [7:0] a, input logic [7:0] s,
		input logic [6:0] sz);
		logic [7:0] keep;
		keep = ~{1'b0, sz};
		return ((a ^ s) & keep) == 8'h00;
	endfunction

	logic above_16m;
	logic base_fwd;

	// region select and forwarding before the hole is applied
	always_comb begin
		above_16m = addr[31:24] != 8'h00;
		base_fwd  = 1'b0;
		region    = IPDC_RGN_LOW;
		if (above_16m) begin
			region   = IPDC_RGN_HIGH;
			base_fwd = 1'b1;
		end else if (addr[23:20] != 4'h0) begin
			region   = IPDC_RGN_EXT;
			// top of memory is (field + 1) megabytes
			base_fwd = addr[23:20] <= decode[7:4];
		end else if (addr[19] == 1'b0) begin
			base_fwd = decode[`IPDC_DEC_512K_BIT];
		end else if (addr[18:17] == 2'b00) begin
			base_fwd = decode[`IPDC_DEC_640K_BIT];
		end else if (addr[18] == 1'b0) begin
			region   = IPDC_RGN_VIDEO;
			base_fwd = decode[`IPDC_DEC_VIDEO_BIT];
		end else if (addr[17] == 1'b0) begin
			region   = IPDC_RGN_ROM;
			base_fwd = rom_fwd[addr[16:14]];
		end else begin
			region   = IPDC_RGN_BIOS;
			// chip select claims the low bios block first
			base_fwd = (addr[16] == 1'b0) && !lbios_cs
				&& decode[`IPDC_DEC_LOWBIOS_BIT];
		end
		in_hole = !above_16m && hole_size[`IPDC_HOLE_EN_BIT]
			&& hole_match(addr[23:16], hole_start, hole_size[6:0]);
		forward = base_fwd && !in_hole;
	end

endmodule

`default_nettype wire

// File: ipdc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ipdc_checker
	import ipdc_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        ide_primary_irq,
	input wire logic        ide_secondary_irq,
	input wire logic [3:0]  pci_int_n,
	input wire logic [15:0] irq_req,
	input wire logic        io_valid,
	input wire logic        timer_hit,
	input wire logic        mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_forward,
	input wire logic        mem_in_hole
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// bus handshake: exactly one wait state, none while idle
	wait_first_a: assert property ((read || write) && !($past(read) || $past(write)) |-> waitrequest)
		else $error("first request cycle not stalled");
	one_wait_a: assert property ((read || write) && waitrequest |=> !(read || write) || !waitrequest)
		else $error("more than one wait state");
	idle_wait_a: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest without request");
	rd_hold_a: assert property (!read |=> $stable(readdata))
		else $error("readdata moved without read");
	// forward and hole flags are cleared when no access is probed
	mem_idle_a: assert property (!mem_valid |=> !mem_forward && !mem_in_hole)
		else $error("decode flags without access");
	high_fwd_a: assert property (mem_valid && mem_addr[31:24] != 8'h00 |=> mem_forward)
		else $error("access above 16M not forwarded");
	bios_top_a: assert property (mem_valid && mem_addr[31:16] == 16'h000F |=> !mem_forward)
		else $error("top bios block forwarded");
	hole_blk_a: assert property (
		mem_in_hole && $past(mem_addr) < 32'h01000000 |-> !mem_forward)
		else $error("hole access forwarded");
	irq_quiet_a: assert property (
		!ide_primary_irq && !ide_secondary_irq && pci_int_n == 4'hF |=> irq_req == 16'h0000)
		else $error("interrupt request without source");
	irq_resv_a: assert property (
		!ide_primary_irq && !ide_secondary_irq |=> (irq_req & 16'h2107) == 16'h0000)
		else $error("pci line routed to reserved channel");
	io_idle_a: assert property (!io_valid |=> !timer_hit)
		else $error("timer hit without io access");
	// main scenarios reached
	hole_c: cover property (mem_valid ##1 mem_in_hole);
	timer_c: cover property (io_valid ##1 timer_hit);
	fwd_c: cover property (mem_valid ##1 mem_forward);
endmodule
`default_nettype wire

// File: ipdc_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module ipdc_far_side (
	input  wire logic        clock,
	output logic             ide_primary_irq,
	output logic             ide_secondary_irq,
	output logic [3:0]       pci_int_n,
	output logic             io_valid,
	output logic [15:0]      io_addr,
	output logic             mem_valid,
	output logic [31:0]      mem_addr
);
	// idle bus, no interrupt asserted
	initial begin
		{ide_primary_irq, ide_secondary_irq, io_valid, io_addr, mem_valid, mem_addr} = '0;
		pci_int_n = 4'hF;
	end
	// each task drives after an edge; the result is settled one edge later
	task automatic mem(input logic v, input logic [31:0] a);
		@(posedge clock);
		mem_valid <= v;
		mem_addr <= v ? a : ~mem_addr; // released address does not keep its value
		@(posedge clock);
		#1;
	endtask
	task automatic io(input logic v, input logic [15:0] a);
		@(posedge clock);
		io_valid <= v;
		io_addr <= v ? a : ~io_addr;
		@(posedge clock);
		#1;
	endtask
	task automatic irq(input logic p, input logic s, input logic [3:0] n);
		@(posedge clock);
		ide_primary_irq <= p;
		ide_secondary_irq <= s;
		pci_int_n <= n;
		@(posedge clock);
		#1;
	endtask
endmodule
`default_nettype wire

// File: test_ipdc_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end
module test_ipdc_top;
	typedef struct packed {
		logic [7:0]  dec, rom, hs, hz;
		logic [31:0] a;
		logic        f, h;
	} ipdc_row_s;
	logic        clock, rst, read, write, waitrequest, timer_hit, mem_forward, mem_in_hole;
	logic        ide_primary_irq, ide_secondary_irq, io_valid, mem_valid;
	logic [7:0]  address;
	logic [31:0] writedata, readdata, mem_addr, rd;
	logic [3:0]  byteenable, pci_int_n;
	logic [15:0] irq_req, io_addr, exp;
	int          fails = 0;
	int          checks = 0;
	logic [7:0]  ri [8] = '{8'h43, 8'h44, 8'h46, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h60};
	logic [15:0] rv [8] = '{16'h00EF, 16'h0000, 16'h0078, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0};
	// decoder set-up, probed address, expected forward and hole flags
	ipdc_row_s   rows [15] = '{
		'{8'h01, 8'h00, 8'h00, 8'h00, 32'h00070000, 1'b1, 1'b0},
		'{8'h02, 8'h00, 8'h00, 8'h00, 32'h00090000, 1'b1, 1'b0},
		'{8'h04, 8'h00, 8'h00, 8'h00, 32'h000A0000, 1'b1, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 32'h000BFFFF, 1'b0, 1'b0},
		'{8'h08, 8'h00, 8'h00, 8'h00, 32'h000E8000, 1'b1, 1'b0},
		'{8'hF7, 8'h00, 8'h00, 8'h00, 32'h000E8000, 1'b0, 1'b0},
		'{8'h00, 8'h01, 8'h00, 8'h00, 32'h000C0000, 1'b1, 1'b0},
		'{8'h00, 8'h7F, 8'h00, 8'h00, 32'h000DC000, 1'b0, 1'b0},
		'{8'h30, 8'h00, 8'h00, 8'h00, 32'h003FFFFF, 1'b1, 1'b0},
		'{8'h30, 8'h00, 8'h00, 8'h00, 32'h00400000, 1'b0, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 32'h01000000, 1'b1, 1'b0},
		'{8'h31, 8'h00, 8'h02, 8'h80, 32'h00020000, 1'b0, 1'b1},
		'{8'h31, 8'h00, 8'h02, 8'h83, 32'h00030000, 1'b0, 1'b1},
		'{8'h31, 8'h00, 8'h02, 8'h80, 32'h00030000, 1'b1, 1'b0},
		'{8'h31, 8'h00, 8'h02, 8'h03, 32'h00020000, 1'b1, 1'b0}};

	ipdc_top DUT (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .ide_primary_irq(ide_primary_irq),
		.ide_secondary_irq(ide_secondary_irq), .pci_int_n(pci_int_n), .irq_req(irq_req),
		.io_valid(io_valid), .io_addr(io_addr), .timer_hit(timer_hit), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .mem_forward(mem_forward), .mem_in_hole(mem_in_hole));
	ipdc_far_side far (.clock(clock), .ide_primary_irq(ide_primary_irq),
		.ide_secondary_irq(ide_secondary_irq), .pci_int_n(pci_int_n), .io_valid(io_valid),
		.io_addr(io_addr), .mem_valid(mem_valid), .mem_addr(mem_addr));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one avalon transfer; request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= {16'h0000, d};
		byteenable <= 4'hF;
		read <= !w;
		write <= w;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		// read data taken at the same edge that ends the wait
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 20) begin
			fails++;
			end_sim();
		end
	endtask

	initial begin
		{rst, read, write, address, writedata, byteenable} = {1'b1, 46'h0};
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		// reset values, unmapped index last
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, ri[i], 16'h0, rd);
			`CHK("reset value", {16'h0, rv[i]}, rd)
		end
		far.irq(1'b1, 1'b1, 4'hF);
		`CHK("irq_req", 16'hC000, irq_req)
		for (int i = 0; i < 15; i++) begin
			bus(1'b1, 8'h48, {8'h00, rows[i].dec}, rd);
			bus(1'b1, 8'h49, {8'h00, rows[i].rom}, rd);
			bus(1'b1, 8'h4A, {8'h00, rows[i].hs}, rd);
			bus(1'b1, 8'h4B, {8'h00, rows[i].hz}, rd);
			far.mem(1'b1, rows[i].a);
			`CHK("mem_forward", rows[i].f, mem_forward)
			`CHK("mem_in_hole", rows[i].h, mem_in_hole)
		end
		// chip select claims the low bios block; top bios block never forwarded
		bus(1'b1, 8'h48, 16'h00FF, rd);
		far.mem(1'b1, 32'h000F8000);
		`CHK("mem_forward", 1'b0, mem_forward)
		bus(1'b1, 8'h4D, 16'h0040, rd);
		far.mem(1'b1, 32'h000E8000);
		`CHK("mem_forward", 1'b0, mem_forward)
		// status is read only: bios region, nothing forwarded
		bus(1'b1, 8'h50, 16'h00FF, rd);
		bus(1'b0, 8'h50, 16'h0, rd);
		`CHK("status", 32'h00000018, rd)
		far.mem(1'b0, 32'h0);
		// reserved bits read back as zero
		bus(1'b1, 8'h42, 16'h00FF, rd);
		bus(1'b0, 8'h42, 16'h0, rd);
		`CHK("line buffer", 32'h0000000F, rd)
		bus(1'b1, 8'h46, 16'hFFFF, rd);
		bus(1'b0, 8'h46, 16'h0, rd);
		`CHK("timer base", 32'h0000FFFD, rd)
		bus(1'b1, 8'h43, 16'h009A, rd);
		far.irq(1'b1, 1'b1, 4'hF);
		`CHK("irq_req", 16'h0600, irq_req)
		bus(1'b1, 8'h44, 16'h3456, rd);
		far.irq(1'b0, 1'b0, 4'h0);
		`CHK("irq_req", 16'h0078, irq_req)
		// every channel value on one line, reserved ones drop it
		for (int v = 0; v < 16; v++) begin
			bus(1'b1, 8'h44, 16'(v) << 12, rd);
			far.irq(1'b0, 1'b0, 4'hE);
			exp = 16'h2107 >> v;
			exp = exp[0] ? 16'h0000 : 16'h0001 << v;
			`CHK("irq_req", exp, irq_req)
		end
		far.irq(1'b0, 1'b0, 4'hF);
		bus(1'b1, 8'h46, 16'h0101, rd);
		far.io(1'b1, 16'h0102);
		`CHK("timer_hit", 1'b1, timer_hit)
		far.io(1'b1, 16'h0104);
		`CHK("timer_hit", 1'b0, timer_hit)
		bus(1'b1, 8'h46, 16'h0100, rd);
		far.io(1'b1, 16'h0100);
		`CHK("timer_hit", 1'b0, timer_hit)
		far.io(1'b0, 16'h0);
		// reset in mid-run brings back the registers read at start; line buffer and chip select not rechecked
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, ri[i], 16'h0, rd);
			`CHK("reset value", {16'h0, rv[i]}, rd)
		end
		end_sim();
	end
endmodule
bind ipdc_top ipdc_checker chk (.clock(clock), .rst(rst), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest), .ide_primary_irq(ide_primary_irq),
	.ide_secondary_irq(ide_secondary_irq), .pci_int_n(pci_int_n), .irq_req(irq_req),
	.io_valid(io_valid), .timer_hit(timer_hit), .mem_valid(mem_valid), .mem_addr(mem_addr),
	.mem_forward(mem_forward), .mem_in_hole(mem_in_hole));
`default_nettype wire
